// *** core/tcs_pkg.sv ***
package tcs_pkg;

    // clock and check timing
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CHECK_MS = 500;
    localparam int CHECK_CYC = CHECK_MS * (CLK_HZ / MS_PER_S);
    localparam int CLEAR_MS = 1500;
    localparam logic [1:0] CLEAR_CHECKS = 2'(CLEAR_MS / CHECK_MS);
    localparam logic [5:0] DUAL_CHECKS = 6'h03;
    localparam int CHECKS_PER_S = MS_PER_S / CHECK_MS;

    // alarm delay setting, seconds
    localparam logic [4:0] DELAY_MIN = 5'h01;
    localparam logic [4:0] DELAY_MAX = 5'h1e;
    localparam logic [4:0] DELAY_RST = 5'h02;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // control fields
    localparam int CTRL_ON = 0;
    localparam int CTRL_DUAL = 1;
    localparam int CTRL_PRESENT = 2;
    localparam int CTRL_ALLOC_TRIP = 3;
    localparam int CTRL_ALLOC_AUX = 4;
    localparam logic [4:0] CTRL_RST = 5'h1e;

    // status fields
    localparam int ST_ALARM = 0;
    localparam int ST_MISMATCH = 1;
    localparam int ST_TRIP_IN = 2;
    localparam int ST_AUX_IN = 3;
    localparam int ST_FAULT = 4;
    localparam int ST_ACTIVE = 5;

    // interrupt fields
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_MISMATCH = 1;

    // sense pin order inside the synchroniser
    localparam int PIN_TRIP = 0;
    localparam int PIN_AUX = 1;
    localparam int PIN_FAULT = 2;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tcs_apb_req_s;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic [2:0] filt;
        logic [22:0] presc;
        logic tick;
        logic [5:0] bad_cnt;
        logic [1:0] good_cnt;
        logic alarm;
        logic mismatch;
        logic [4:0] ctrl;
        logic [4:0] delay;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tcs_state_s;

endpackage

// *** core/tcs_supervisor.sv ***
// Behaviour
// - one or two sensing inputs selectable
// - allocation misfit raises mismatch, no supervision
// - dual: trip high open, aux high tripped
// - dual: both inputs low is fault
// - dual: check inputs every 500 ms
// - dual: alarm after three consecutive abnormal checks
// - dual: alarm self-clears after 1.5 s
// - single: input high healthy, low tripping
// - single: persistent low means broken circuit
// - supervision suspended during system fault
// - single: alarm delay 1..30 s, default 2
// - single: alarm self-clears after 1.5 s
// - function present only when configured
// - on/off switch, default off, gates alarms
// - input count setting, default two
`timescale 1ns/1ps
`default_nettype none

module tcs_supervisor
    import tcs_pkg::*;
#(
    parameter int TICK_CYC = CHECK_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire tcs_apb_req_s apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // trip circuit sensing pins
    input wire logic sense_across_trip_contact_i,
    input wire logic sense_across_breaker_aux_i,
    input wire logic fault_active_i,
    // indications
    output logic trip_circuit_fail_o,
    output logic config_mismatch_alarm_o,
    output logic irq_o
);

    tcs_state_s s_r;
    tcs_state_s s_nxt;

    logic dual;
    logic present;
    logic sup_on;
    logic mm;
    logic act;
    logic abnormal;
    logic frozen;
    logic [5:0] limit;
    logic xfer;
    logic rd;
    logic wr;
    logic mapped;
    logic [31:0] rdata;
    logic [4:0] wdelay;

    function automatic logic is_mapped(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_DELAY || a == ADDR_STATUS
            || a == ADDR_IRQ_STAT || a == ADDR_IRQ_MASK;
    endfunction

    function automatic logic [4:0] clamp_delay(input logic [31:0] v);
        if (v < 32'(DELAY_MIN)) begin
            return DELAY_MIN;
        end
        if (v > 32'(DELAY_MAX)) begin
            return DELAY_MAX;
        end
        return v[4:0];
    endfunction

    always_comb begin
        s_nxt = s_r;

        // pins through three flops, accepted once stages two and three agree
        s_nxt.sync1 = {fault_active_i, sense_across_breaker_aux_i,
                       sense_across_trip_contact_i};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        for (int i = 0; i < 3; i++) begin
            if (s_r.sync2[i] == s_r.sync3[i]) begin
                s_nxt.filt[i] = s_r.sync3[i];
            end
        end

        // periodic check tick
        s_nxt.tick = 1'b0;
        if (s_r.presc == 23'(TICK_CYC - 1)) begin
            s_nxt.presc = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.presc = s_r.presc + 23'h000001;
        end

        dual = s_r.ctrl[CTRL_DUAL];
        present = s_r.ctrl[CTRL_PRESENT];
        sup_on = s_r.ctrl[CTRL_ON];

        // dual needs both pins allocated, single needs the trip pin
        if (dual) begin
            mm = !(s_r.ctrl[CTRL_ALLOC_TRIP]
                   && s_r.ctrl[CTRL_ALLOC_AUX]);
        end else begin
            mm = !s_r.ctrl[CTRL_ALLOC_TRIP];
        end
        mm = mm && present && sup_on;
        act = present && sup_on && !mm;

        if (dual) begin
            // trip pin high when contact open, aux high when breaker tripped
            abnormal = !s_r.filt[PIN_TRIP]
                && !s_r.filt[PIN_AUX];
            limit = DUAL_CHECKS;
        end else begin
            // trip pin low only while contact closed or circuit broken
            abnormal = !s_r.filt[PIN_TRIP];
            limit = 6'(s_r.delay) * 6'(CHECKS_PER_S);
        end
        frozen = s_r.filt[PIN_FAULT];

        s_nxt.mismatch = mm;

        if (!act) begin
            s_nxt.bad_cnt = '0;
            s_nxt.good_cnt = '0;
            s_nxt.alarm = 1'b0;
        end else if (s_r.tick && !frozen) begin
            if (abnormal) begin
                s_nxt.good_cnt = '0;
                if (s_r.bad_cnt < limit) begin
                    s_nxt.bad_cnt = s_r.bad_cnt + 6'h01;
                end
                if (s_r.bad_cnt + 6'h01 >= limit) begin
                    s_nxt.alarm = 1'b1;
                end
            end else begin
                s_nxt.bad_cnt = '0;
                if (s_r.alarm) begin
                    if (s_r.good_cnt + 2'h1 >= CLEAR_CHECKS) begin
                        s_nxt.alarm = 1'b0;
                        s_nxt.good_cnt = '0;
                    end else begin
                        s_nxt.good_cnt = s_r.good_cnt + 2'h1;
                    end
                end
            end
        end

        // apb: one wait state, answer on the second access cycle
        xfer = apb_i.psel && apb_i.penable && s_r.pready;
        rd = xfer && !apb_i.pwrite;
        wr = xfer && apb_i.pwrite;
        mapped = is_mapped(apb_i.paddr);
        wdelay = clamp_delay(apb_i.pwdata);

        rdata = '0;
        unique case (apb_i.paddr)
            ADDR_CTRL: begin
                rdata[4:0] = s_r.ctrl;
            end
            ADDR_DELAY: begin
                rdata[4:0] = s_r.delay;
            end
            ADDR_STATUS: begin
                rdata[ST_ALARM] = s_r.alarm;
                rdata[ST_MISMATCH] = s_r.mismatch;
                rdata[ST_TRIP_IN] = s_r.filt[PIN_TRIP];
                rdata[ST_AUX_IN] = s_r.filt[PIN_AUX];
                rdata[ST_FAULT] = s_r.filt[PIN_FAULT];
                rdata[ST_ACTIVE] = act;
            end
            ADDR_IRQ_STAT: begin
                rdata[1:0] = s_r.irq_stat;
            end
            ADDR_IRQ_MASK: begin
                rdata[1:0] = s_r.irq_mask;
            end
            default: begin
                rdata = '0;
            end
        endcase

        s_nxt.pready = apb_i.psel && apb_i.penable && !s_r.pready;
        s_nxt.pslverr = s_nxt.pready && !mapped;
        if (s_nxt.pready && !apb_i.pwrite) begin
            s_nxt.prdata = rdata;
        end

        if (wr && apb_i.paddr == ADDR_CTRL) begin
            s_nxt.ctrl = apb_i.pwdata[4:0];
        end
        if (wr && apb_i.paddr == ADDR_DELAY) begin
            s_nxt.delay = wdelay;
        end
        if (wr && apb_i.paddr == ADDR_IRQ_MASK) begin
            s_nxt.irq_mask = apb_i.pwdata[1:0];
        end

        // read clears, a new event in the same cycle wins
        if (rd && apb_i.paddr == ADDR_IRQ_STAT) begin
            s_nxt.irq_stat = '0;
        end
        if (s_nxt.alarm && !s_r.alarm) begin
            s_nxt.irq_stat[IRQ_ALARM] = 1'b1;
        end
        if (mm && !s_r.mismatch) begin
            s_nxt.irq_stat[IRQ_MISMATCH] = 1'b1;
        end
        s_nxt.irq = |(s_r.irq_stat & s_r.irq_mask);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.delay <= DELAY_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o = s_r.prdata;
    assign pready_o = s_r.pready;
    assign pslverr_o = s_r.pslverr;
    assign trip_circuit_fail_o = s_r.alarm;
    assign config_mismatch_alarm_o = s_r.mismatch;
    assign irq_o = s_r.irq;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_off_no_alarm: assert property (
        !s_r.ctrl[CTRL_ON] |=> !s_r.alarm)
        else $error("alarm while supervision off");

    a_absent_no_alarm: assert property (
        !s_r.ctrl[CTRL_PRESENT] |=> !s_r.alarm && !s_r.mismatch)
        else $error("indication while function absent");

    a_mismatch_blocks: assert property (
        s_r.mismatch |-> !s_r.alarm)
        else $error("alarm raised during configuration mismatch");

    a_dual_three_checks: assert property (
        $rose(s_r.alarm) && s_r.ctrl[CTRL_DUAL]
        |-> s_r.bad_cnt == DUAL_CHECKS && $past(s_r.tick))
        else $error("dual alarm not after three checks");

    a_single_delay: assert property (
        $rose(s_r.alarm) && !s_r.ctrl[CTRL_DUAL]
        |-> s_r.bad_cnt == 6'(s_r.delay) * 6'(CHECKS_PER_S))
        else $error("single alarm delay wrong");

    a_clear_after_three: assert property (
        $fell(s_r.alarm) && $past(act)
        |-> $past(s_r.good_cnt) == CLEAR_CHECKS - 2'h1)
        else $error("alarm cleared at wrong time");

    a_fault_freezes: assert property (
        s_r.filt[PIN_FAULT] && act && s_r.ctrl[CTRL_ON]
        |=> !act || (s_r.bad_cnt == $past(s_r.bad_cnt)
                     && s_r.alarm == $past(s_r.alarm)))
        else $error("supervision ran during system fault");

    a_tick_period: assert property (
        s_r.tick |=> !s_r.tick)
        else $error("check tick too frequent");

    a_delay_range: assert property (
        s_r.delay >= DELAY_MIN && s_r.delay <= DELAY_MAX)
        else $error("alarm delay out of range");

    a_dual_healthy: assert property (
        s_r.tick && act && s_r.ctrl[CTRL_DUAL] && !s_r.filt[PIN_FAULT]
        && (s_r.filt[PIN_TRIP] || s_r.filt[PIN_AUX]) |=> s_r.bad_cnt == 6'h00)
        else $error("healthy dual state counted as abnormal");

    a_irq_level: assert property (
        s_r.irq == $past(|(s_r.irq_stat & s_r.irq_mask)))
        else $error("interrupt output does not follow status");

    // pin filter: a level is taken only when stages two and three agree
    a_sync_trip: assert property (
        s_r.sync2[PIN_TRIP] == s_r.sync3[PIN_TRIP]
        |=> s_r.filt[PIN_TRIP] == $past(s_r.sync3[PIN_TRIP]))
        else $error("trip pin filter took wrong level");

    a_sync_aux: assert property (
        s_r.sync2[PIN_AUX] == s_r.sync3[PIN_AUX]
        |=> s_r.filt[PIN_AUX] == $past(s_r.sync3[PIN_AUX]))
        else $error("aux pin filter took wrong level");

    a_sync_fault: assert property (
        s_r.sync2[PIN_FAULT] == s_r.sync3[PIN_FAULT]
        |=> s_r.filt[PIN_FAULT] == $past(s_r.sync3[PIN_FAULT]))
        else $error("fault pin filter took wrong level");

    a_sync_hold: assert property (
        s_r.sync2[PIN_TRIP] != s_r.sync3[PIN_TRIP]
        |=> s_r.filt[PIN_TRIP] == $past(s_r.filt[PIN_TRIP]))
        else $error("trip pin filter moved on disagreeing stages");

    // tick restarts the prescaler
    a_tick_reload: assert property (
        s_r.tick |-> s_r.presc == 23'h000000)
        else $error("check tick without prescaler reload");

    a_presc_range: assert property (
        s_r.presc < 23'(TICK_CYC))
        else $error("prescaler out of range");

    // while active, counters only move on a check
    a_no_tick_hold: assert property (
        !s_r.tick && act |=> s_r.bad_cnt == $past(s_r.bad_cnt))
        else $error("check counter moved between ticks");

    a_single_healthy: assert property (
        s_r.tick && act && !s_r.ctrl[CTRL_DUAL] && !s_r.filt[PIN_FAULT]
        && s_r.filt[PIN_TRIP] |=> s_r.bad_cnt == 6'h00)
        else $error("healthy single input counted as abnormal");

    a_single_count: assert property (
        s_r.tick && act && !s_r.ctrl[CTRL_DUAL] && !s_r.filt[PIN_FAULT]
        && !s_r.filt[PIN_TRIP] && s_r.bad_cnt < limit |=> s_r.bad_cnt == $past(s_r.bad_cnt) + 6'h01)
        else $error("low single input not counted");

    a_dual_count: assert property (
        s_r.tick && act && s_r.ctrl[CTRL_DUAL] && !s_r.filt[PIN_FAULT] && !s_r.filt[PIN_TRIP]
        && !s_r.filt[PIN_AUX] && s_r.bad_cnt < DUAL_CHECKS |=> s_r.bad_cnt == $past(s_r.bad_cnt) + 6'h01)
        else $error("both inputs low not counted");

    // dual mode needs both pins, single mode only the trip pin
    a_mismatch_dual: assert property (
        s_r.ctrl[CTRL_ON] && s_r.ctrl[CTRL_PRESENT] && s_r.ctrl[CTRL_DUAL]
        && !s_r.ctrl[CTRL_ALLOC_AUX] |=> s_r.mismatch)
        else $error("dual mode without aux pin not flagged");

    a_mismatch_single: assert property (
        s_r.ctrl[CTRL_ON] && s_r.ctrl[CTRL_PRESENT] && !s_r.ctrl[CTRL_DUAL]
        && s_r.ctrl[CTRL_ALLOC_TRIP] |=> !s_r.mismatch)
        else $error("single mode with trip pin flagged");

    a_alarm_on_tick: assert property (
        $rose(s_r.alarm) |-> $past(s_r.tick) && $past(act))
        else $error("alarm raised outside a check");

    a_good_bound: assert property (
        s_r.good_cnt < CLEAR_CHECKS)
        else $error("clear counter overran");

    a_bad_bound: assert property (
        s_r.bad_cnt <= 6'h3c)
        else $error("check counter beyond longest delay");

    c_fault_hold: cover property (s_r.filt[PIN_FAULT] && act && s_r.tick);
    c_dual_alarm: cover property (
        $rose(s_r.alarm) && s_r.ctrl[CTRL_DUAL]);
    c_single_alarm: cover property (
        $rose(s_r.alarm) && !s_r.ctrl[CTRL_DUAL]);
    c_mismatch: cover property ($rose(s_r.mismatch));
    c_alarm_clear: cover property ($fell(s_r.alarm) && $past(act));

endmodule

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    import tcs_pkg::*;
    localparam int T = 20;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    tcs_apb_req_s apb = '0;
    logic [31:0] prdata;
    logic pready, pslverr, fail, mism, irq, trip_pin, aux_pin;
    logic closed = 1'b0, tripped = 1'b0, ok = 1'b1, fault = 1'b0;
    logic [31:0] rd;
    logic err;
    logic [1:0] st;
    int failures = 0;
    int samples_checked = 0;
    int d;

    tcs_supervisor #(.TICK_CYC(T)) DUT (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .apb_i(apb),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .sense_across_trip_contact_i(trip_pin),
        .sense_across_breaker_aux_i(aux_pin),
        .fault_active_i(fault),
        .trip_circuit_fail_o(fail),
        .config_mismatch_alarm_o(mism),
        .irq_o(irq)
    );

    tcs_trip_circuit_model circuit (
        .contact_closed_i(closed),
        .breaker_tripped_i(tripped),
        .circuit_ok_i(ok),
        .sense_trip_o(trip_pin),
        .sense_aux_o(aux_pin)
    );

    initial forever #50 ref_clk_i = ~ref_clk_i;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        apb <= '{1'b1, 1'b0, w, a, wd};
        @(posedge ref_clk_i);
        apb.penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        apb <= '0;
        if (n >= 50) failures++;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #(100 * 300 * T);
        failures++;
        final_report();
    end

    initial begin
        void'($urandom(66152));
        cyc(4);
        rst_n_i <= 1'b1;
        rchk("ctrl reset", ADDR_CTRL, 32'h1e);
        rchk("delay reset", ADDR_DELAY, 32'h2);
        rchk("mask reset", ADDR_IRQ_MASK, 32'h0);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        ok <= 1'b0;
        cyc(6 * T);
        chk("alarm while off", fail, 1'b0);
        xfer(1'b1, ADDR_IRQ_MASK, 32'h3);
        xfer(1'b1, ADDR_CTRL, 32'h1f);
        cyc(T);
        chk("alarm early", fail, 1'b0);
        cyc(3 * T);
        chk("alarm dual", fail, 1'b1);
        chk("irq raised", irq, 1'b1);
        rchk("irq status", ADDR_IRQ_STAT, 32'h1);
        cyc(3);
        chk("irq cleared", irq, 1'b0);
        ok <= 1'b1;
        cyc(T);
        chk("alarm held", fail, 1'b1);
        cyc(3 * T);
        chk("alarm cleared", fail, 1'b0);
        for (int k = 0; k < 4; k++) begin
            st = (k == 3) ? 2'b10 : ((k == 2) ? 2'b11 : 2'(k));
            closed <= st[1];
            tripped <= st[0];
            cyc(5 * T);
            xfer(1'b0, ADDR_STATUS, 32'h0);
            chk("pin status", {30'h0, rd[3:2]}, {30'h0, st[0], ~st[1]});
            chk("table alarm", fail, st == 2'b10);
        end
        closed <= 1'b0;
        cyc(5 * T);
        closed <= 1'b1;
        cyc(T);
        closed <= 1'b0;
        cyc(4 * T);
        chk("short transition", fail, 1'b0);
        fault <= 1'b1;
        ok <= 1'b0;
        cyc(8 * T);
        chk("alarm in fault", fail, 1'b0);
        fault <= 1'b0;
        ok <= 1'b1;
        xfer(1'b1, ADDR_CTRL, 32'h0f);
        cyc(2);
        chk("mismatch dual", mism, 1'b1);
        xfer(1'b1, ADDR_CTRL, 32'h0d);
        cyc(2);
        chk("single fits", mism, 1'b0);
        xfer(1'b1, ADDR_CTRL, 32'h0b);
        ok <= 1'b0;
        cyc(6 * T);
        chk("absent mismatch", mism, 1'b0);
        chk("absent alarm", fail, 1'b0);
        ok <= 1'b1;
        xfer(1'b1, ADDR_DELAY, 32'h0);
        rchk("delay low clamp", ADDR_DELAY, 32'h1);
        xfer(1'b1, ADDR_DELAY, 32'h1f);
        rchk("delay high clamp", ADDR_DELAY, 32'h1e);
        d = 1 + ($urandom % 3);
        xfer(1'b1, ADDR_DELAY, 32'(d));
        xfer(1'b1, ADDR_CTRL, 32'h0d);
        cyc(2 * T);
        closed <= 1'b1;
        cyc((2 * d - 1) * T - 2);
        chk("single early", fail, 1'b0);
        cyc(T + 10);
        chk("single alarm", fail, 1'b1);
        closed <= 1'b0;
        cyc(T);
        chk("single held", fail, 1'b1);
        cyc(3 * T);
        chk("single cleared", fail, 1'b0);
        final_report();
    end
endmodule

`default_nettype wire

// *** testbench/tcs_trip_circuit_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// trip circuit seen as logic levels at the two sensing pins
module tcs_trip_circuit_model (
    // circuit state
    input wire logic contact_closed_i,
    input wire logic breaker_tripped_i,
    input wire logic circuit_ok_i,
    // sensing pins
    output logic sense_trip_o,
    output logic sense_aux_o
);
    // a broken circuit or lost supply pulls both inputs low
    assign sense_trip_o = circuit_ok_i & ~contact_closed_i;
    assign sense_aux_o = circuit_ok_i & breaker_tripped_i;
endmodule

`default_nettype wire
